// *** euart_regs.svh ***
`ifndef EUART_REGS_SVH
`define EUART_REGS_SVH

// Register word indices; byte address is four times the index
`define EUART_CTRL_IDX 3'h0
`define EUART_STAT_IDX 3'h1
`define EUART_DATA_IDX 3'h2
`define EUART_DIVL_IDX 3'h3
`define EUART_DIVH_IDX 3'h4
`define EUART_PWR_IDX 3'h5
`define EUART_SRC_IDX 3'h6

// Port control register fields
`define EUART_CTRL_SM0 7
`define EUART_CTRL_SM1 6
`define EUART_CTRL_SM2 5
`define EUART_CTRL_REN 4
`define EUART_CTRL_TB8 3
`define EUART_CTRL_RB8 2
`define EUART_CTRL_TI 1
`define EUART_CTRL_RI 0

// Port status register fields
`define EUART_STAT_DBMOD 7
`define EUART_STAT_FE 3
`define EUART_STAT_BR 2
`define EUART_STAT_BUSY 1
`define EUART_STAT_HOLD 0

// Power control and rate source fields
`define EUART_PWR_RDBL 7
`define EUART_PWR_FEV 6
`define EUART_SRC_BRG 0

// Reset values
`define EUART_BYTE_RST 8'h00
`define EUART_DIV_RST 16'h0000

// Timing counts
`define EUART_LAST_TICK 4'hF
`define EUART_MID_TICK 4'h7
`define EUART_M0_SAMPLE 4'h8
`define EUART_BREAK_TICKS 8'hAF
`define EUART_LAST_DATA 4'h7

`endif

// *** euart_pkg.sv ***
package euart_pkg;

  // Operating mode, encoded as {mode_select_bit0, mode_select_bit1}
  typedef enum logic [1:0] {
    EUART_SHIFT = 2'h0,
    EUART_ASYNC8 = 2'h1,
    EUART_FIX9 = 2'h2,
    EUART_VAR9 = 2'h3
  } euart_mode_e;

  // Transmit sequencer, Gray coded along start, data, ninth, stop
  typedef enum logic [2:0] {
    EUART_TX_IDLE = 3'h0,
    EUART_TX_START = 3'h1,
    EUART_TX_DATA = 3'h3,
    EUART_TX_NINTH = 3'h2,
    EUART_TX_STOP = 3'h6,
    EUART_TX_SHIFT0 = 3'h7
  } euart_tx_e;

  // Asynchronous receive sequencer
  typedef enum logic [1:0] {
    EUART_RX_IDLE = 2'h0,
    EUART_RX_START = 2'h1,
    EUART_RX_BITS = 2'h3,
    EUART_RX_STOP = 2'h2
  } euart_rx_e;

  // One character with its ninth bit
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } euart_char_s;

endpackage : euart_pkg

// *** euart_rate_gen.sv ***
`timescale 1ns/1ps
`include "euart_regs.svh"

module euart_rate_gen #(
  parameter int DIV_W = 16
) (
  input wire logic core_clk, // CPU clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic enable, // Generator selected as rate source
  input wire logic [DIV_W-1:0] divisor, // Clocks per tick minus one
  output logic tick // One-cycle oversampling tick
);

  logic [DIV_W-1:0] cnt_q;

  // Down counter reloads from the divisor
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !enable)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (cnt_q == '0)
    begin
      cnt_q <= divisor;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : euart_rate_gen

// *** euart_top.sv ***
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "euart_regs.svh"

// Overview of operation
// - Shift mode: data on input pin, clock out
// - Async8 frame: start, eight data, stop
// - Async8 receive stores stop into rx_ninth_bit
// - Async8 rate from timer overflow or generator
// - Nine-bit frame, ninth bit from tx_ninth_bit
// - Fixed nine-bit rate clock/16 or clock/32
// - Variable nine-bit like fixed, other rate
// - Own 16-bit divisor generator per port
// - Timer overflow halved when rate_double_select clear
// - Rate source: constant, timer, own generator
// - Framing error in status, optionally control bit7
// - Break flagged after 11 low bit times
// - Break can request device reset into programming
// - Buffered character sent back to back
// - Double buffer enable gates buffered writes
// - Done flag when double buffer frees
// - Double buffer captures ninth bit with data
module euart_top (
  input wire logic core_clk, // CPU clock, 200 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer is ready
  input wire logic t1_overflow, // Timer 1 overflow pulse
  input wire logic serial_in_pin, // Receive pin level
  output logic serial_data_out, // Receive pin drive in shift mode
  output logic serial_data_oe, // Receive pin output enable
  output logic serial_out_pin, // Transmit pin or shift clock
  output logic break_reset_req // Pulse: break asks for device reset
);

  euart_pkg::euart_mode_e mode;
  euart_pkg::euart_tx_e tx_st_q;
  euart_pkg::euart_rx_e rx_st_q;
  euart_pkg::euart_char_s hold_q;
  logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
  logic dbmod_q, fe_q, br_q, rdbl_q, fev_q, src_brg_q;
  logic hold_v_q;
  logic [7:0] div_lo_q, div_hi_q, rx_data_q;
  logic acc, wr_en, rd_en;
  logic tx_take, ti_set, ri_set, rb8_val, fe_set, br_set;
  logic m0_rx_done, tick16, brg_tick, div2_q, t1_half_q;
  logic [3:0] tx_cnt_q, tx_bit_q, m0_nxt, rx_cnt_q, rx_bit_q;
  logic [7:0] tx_sh_q, brk_cnt_q;
  logic tx_ninth_q, m0_rx_q, tx_bit_end, rx_prev_q, rx_sample;
  logic [8:0] rx_sh_q;
  logic [7:0] rd_mux;

  // Last bit index after start, ninth included
  function automatic logic [3:0] last_bit(input euart_pkg::euart_mode_e m);
    last_bit = (m == euart_pkg::EUART_FIX9 || m == euart_pkg::EUART_VAR9) ? 4'h8 : 4'h7;
  endfunction : last_bit

  assign mode = euart_pkg::euart_mode_e'({sm0_q, sm1_q});
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_en = acc && avs_write && avs_byteenable[0];
  assign rd_en = avs_read && avs_waitrequest;

  // One wait state per access; read data are ready when waitrequest drops
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  // Read multiplexer; unmapped words read as zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (avs_address[4:2])
      `EUART_CTRL_IDX: rd_mux = {fev_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q,
                                 tb8_q, rb8_q, ti_q, ri_q};
      `EUART_STAT_IDX: rd_mux = {dbmod_q, 3'h0, fe_q, br_q,
                                 tx_st_q != euart_pkg::EUART_TX_IDLE, hold_v_q};
      `EUART_DATA_IDX: rd_mux = rx_data_q;
      `EUART_DIVL_IDX: rd_mux = div_lo_q;
      `EUART_DIVH_IDX: rd_mux = div_hi_q;
      `EUART_PWR_IDX: rd_mux = {rdbl_q, fev_q, 6'h00};
      `EUART_SRC_IDX: rd_mux = {7'h00, src_brg_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the stalled cycle and held afterwards
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      avs_readdata <= 32'h0000_0000;
    else if (rd_en)
      avs_readdata <= {24'h00_0000, rd_mux};
  end

  // Control bits; hardware set beats a clear
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      {sm0_q, sm1_q, sm2_q, ren_q, tb8_q} <= 5'h00;
      rb8_q <= 1'b0;
      ti_q <= 1'b0;
      ri_q <= 1'b0;
    end
    else
    begin
      if (wr_en && avs_address[4:2] == `EUART_CTRL_IDX)
      begin
        if (!fev_q)
          sm0_q <= avs_writedata[`EUART_CTRL_SM0];
        sm1_q <= avs_writedata[`EUART_CTRL_SM1];
        sm2_q <= avs_writedata[`EUART_CTRL_SM2];
        ren_q <= avs_writedata[`EUART_CTRL_REN];
        tb8_q <= avs_writedata[`EUART_CTRL_TB8];
        rb8_q <= avs_writedata[`EUART_CTRL_RB8];
        ti_q <= avs_writedata[`EUART_CTRL_TI];
        ri_q <= avs_writedata[`EUART_CTRL_RI];
      end
      if (ti_set)
        ti_q <= 1'b1;
      if (ri_set)
      begin
        ri_q <= 1'b1;
        rb8_q <= rb8_val;
      end
    end
  end

  // Status, power, source and divisor
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      dbmod_q <= 1'b0;
      fe_q <= 1'b0;
      br_q <= 1'b0;
      rdbl_q <= 1'b0;
      fev_q <= 1'b0;
      src_brg_q <= 1'b0;
      div_lo_q <= `EUART_BYTE_RST;
      div_hi_q <= `EUART_BYTE_RST;
    end
    else
    begin
      if (wr_en)
      begin
        case (avs_address[4:2])
          `EUART_STAT_IDX:
          begin
            dbmod_q <= avs_writedata[`EUART_STAT_DBMOD];
            fe_q <= fe_q && avs_writedata[`EUART_STAT_FE];
            br_q <= br_q && avs_writedata[`EUART_STAT_BR];
          end
          `EUART_CTRL_IDX:
            if (fev_q)
              fe_q <= fe_q && avs_writedata[`EUART_CTRL_SM0];
          `EUART_DIVL_IDX: div_lo_q <= avs_writedata[7:0];
          `EUART_DIVH_IDX: div_hi_q <= avs_writedata[7:0];
          `EUART_PWR_IDX:
          begin
            rdbl_q <= avs_writedata[`EUART_PWR_RDBL];
            fev_q <= avs_writedata[`EUART_PWR_FEV];
          end
          `EUART_SRC_IDX: src_brg_q <= avs_writedata[`EUART_SRC_BRG];
          default: ;
        endcase
      end
      if (fe_set)
        fe_q <= 1'b1;
      if (br_set)
        br_q <= 1'b1;
    end
  end

  // Transmit holding buffer; single-buffered ports refuse writes while busy
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      hold_q <= '0;
      hold_v_q <= 1'b0;
    end
    else if (wr_en && avs_address[4:2] == `EUART_DATA_IDX && !hold_v_q &&
             (dbmod_q || tx_st_q == euart_pkg::EUART_TX_IDLE))
    begin
      hold_q <= '{ninth: tb8_q, data: avs_writedata[7:0]};
      hold_v_q <= 1'b1;
    end
    else if (tx_take)
      hold_v_q <= 1'b0;
  end

  // Oversampling tick: Timer 1 path is halved unless rate doubling is on
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      div2_q <= 1'b0;
      t1_half_q <= 1'b0;
    end
    else
    begin
      div2_q <= !div2_q;
      if (t1_overflow)
        t1_half_q <= !t1_half_q;
    end
  end

  always_comb
  begin
    case (mode)
      euart_pkg::EUART_FIX9: tick16 = rdbl_q || div2_q;
      euart_pkg::EUART_ASYNC8, euart_pkg::EUART_VAR9:
        tick16 = src_brg_q ? brg_tick : t1_overflow && (rdbl_q || t1_half_q);
      default: tick16 = 1'b0;
    endcase
  end

  euart_rate_gen #(
    .DIV_W(16)
  ) u_rate_gen (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(src_brg_q),
    .divisor({div_hi_q, div_lo_q}),
    .tick(brg_tick)
  );

  // Transmit events; a buffered character starts right after a stop bit
  assign tx_bit_end = tick16 && tx_cnt_q == `EUART_LAST_TICK;
  assign m0_nxt = tx_cnt_q + 4'h1;
  always_comb
  begin
    tx_take = 1'b0;
    ti_set = 1'b0;
    m0_rx_done = 1'b0;
    case (tx_st_q)
      euart_pkg::EUART_TX_IDLE: tx_take = hold_v_q;
      euart_pkg::EUART_TX_STOP:
        if (tx_bit_end)
        begin
          tx_take = hold_v_q && dbmod_q;
          ti_set = !dbmod_q;
        end
      euart_pkg::EUART_TX_SHIFT0:
        if (tx_cnt_q == `EUART_LAST_TICK && tx_bit_q == `EUART_LAST_DATA)
        begin
          ti_set = !m0_rx_q;
          m0_rx_done = m0_rx_q;
        end
      default: ;
    endcase
    if (tx_take && dbmod_q)
      ti_set = 1'b1;
  end

  // Transmit sequencer, also the shift-mode engine
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tx_st_q <= euart_pkg::EUART_TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 8'h00;
      tx_ninth_q <= 1'b0;
      m0_rx_q <= 1'b0;
      serial_out_pin <= 1'b1;
      serial_data_out <= 1'b1;
      serial_data_oe <= 1'b0;
    end
    else
    begin
      if (tick16)
        tx_cnt_q <= tx_cnt_q + 4'h1;
      case (tx_st_q)
        euart_pkg::EUART_TX_IDLE:
        begin
          tx_cnt_q <= 4'h0;
          tx_bit_q <= 4'h0;
          serial_data_oe <= 1'b0;
          if (mode == euart_pkg::EUART_SHIFT)
          begin
            if (hold_v_q || (ren_q && !ri_q))
            begin
              tx_st_q <= euart_pkg::EUART_TX_SHIFT0;
              m0_rx_q <= !hold_v_q;
              tx_sh_q <= hold_q.data;
              serial_out_pin <= 1'b0;
              serial_data_out <= hold_q.data[0];
              serial_data_oe <= hold_v_q;
            end
          end
          else if (hold_v_q)
          begin
            tx_st_q <= euart_pkg::EUART_TX_START;
            tx_sh_q <= hold_q.data;
            tx_ninth_q <= hold_q.ninth;
            serial_out_pin <= 1'b0;
          end
        end
        euart_pkg::EUART_TX_START:
          if (tx_bit_end)
          begin
            tx_st_q <= euart_pkg::EUART_TX_DATA;
            serial_out_pin <= tx_sh_q[0];
          end
        euart_pkg::EUART_TX_DATA:
          if (tx_bit_end)
          begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q != `EUART_LAST_DATA)
              serial_out_pin <= tx_sh_q[1];
            else if (last_bit(mode) != `EUART_LAST_DATA)
            begin
              tx_st_q <= euart_pkg::EUART_TX_NINTH;
              serial_out_pin <= dbmod_q ? tx_ninth_q : tb8_q;
            end
            else
            begin
              tx_st_q <= euart_pkg::EUART_TX_STOP;
              serial_out_pin <= 1'b1;
            end
          end
        euart_pkg::EUART_TX_NINTH:
          if (tx_bit_end)
          begin
            tx_st_q <= euart_pkg::EUART_TX_STOP;
            serial_out_pin <= 1'b1;
          end
        euart_pkg::EUART_TX_STOP:
          if (tx_bit_end)
          begin
            tx_bit_q <= 4'h0;
            if (tx_take)
            begin
              tx_st_q <= euart_pkg::EUART_TX_START;
              tx_sh_q <= hold_q.data;
              tx_ninth_q <= hold_q.ninth;
              serial_out_pin <= 1'b0;
            end
            else
              tx_st_q <= euart_pkg::EUART_TX_IDLE;
          end
        euart_pkg::EUART_TX_SHIFT0:
        begin
          // Sixteen clocks per bit: clock low first half, sample one clock after the rise
          tx_cnt_q <= m0_nxt;
          serial_out_pin <= m0_nxt[3];
          if (m0_rx_q && tx_cnt_q == `EUART_M0_SAMPLE)
            tx_sh_q <= {serial_in_pin, tx_sh_q[7:1]};
          if (tx_cnt_q == `EUART_LAST_TICK)
          begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (!m0_rx_q)
            begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              serial_data_out <= tx_sh_q[1];
            end
            if (tx_bit_q == `EUART_LAST_DATA)
            begin
              tx_st_q <= euart_pkg::EUART_TX_IDLE;
              serial_out_pin <= 1'b1;
              serial_data_out <= 1'b1;
              serial_data_oe <= 1'b0;
            end
          end
        end
        default: tx_st_q <= euart_pkg::EUART_TX_IDLE;
      endcase
    end
  end

  // Receive events; a character arriving while the flag is set is dropped
  assign rx_sample = tick16 && rx_cnt_q == `EUART_LAST_TICK;
  always_comb
  begin
    ri_set = m0_rx_done;
    rb8_val = rb8_q;
    fe_set = 1'b0;
    if (rx_st_q == euart_pkg::EUART_RX_STOP && rx_sample)
    begin
      fe_set = !serial_in_pin;
      ri_set = !ri_q;
      rb8_val = (mode == euart_pkg::EUART_ASYNC8) ? serial_in_pin : rx_sh_q[8];
    end
  end

  // Asynchronous receiver, centre sampled from the oversampling tick
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_st_q <= euart_pkg::EUART_RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_prev_q <= 1'b1;
      rx_data_q <= 8'h00;
    end
    else
    begin
      rx_prev_q <= serial_in_pin;
      if (tick16)
        rx_cnt_q <= rx_cnt_q + 4'h1;
      if (m0_rx_done)
        rx_data_q <= tx_sh_q;
      case (rx_st_q)
        euart_pkg::EUART_RX_IDLE:
        begin
          rx_cnt_q <= 4'h0;
          rx_bit_q <= 4'h0;
          if (mode != euart_pkg::EUART_SHIFT && ren_q && rx_prev_q && !serial_in_pin)
            rx_st_q <= euart_pkg::EUART_RX_START;
        end
        euart_pkg::EUART_RX_START:
          if (tick16 && rx_cnt_q == `EUART_MID_TICK)
          begin
            rx_cnt_q <= 4'h0;
            rx_st_q <= serial_in_pin ? euart_pkg::EUART_RX_IDLE : euart_pkg::EUART_RX_BITS;
          end
        euart_pkg::EUART_RX_BITS:
          if (rx_sample)
          begin
            rx_sh_q <= {serial_in_pin, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit(mode))
              rx_st_q <= euart_pkg::EUART_RX_STOP;
          end
        euart_pkg::EUART_RX_STOP:
          if (rx_sample)
          begin
            rx_st_q <= euart_pkg::EUART_RX_IDLE;
            if (!ri_q)
              rx_data_q <= (mode == euart_pkg::EUART_ASYNC8) ? rx_sh_q[8:1] : rx_sh_q[7:0];
          end
        default: rx_st_q <= euart_pkg::EUART_RX_IDLE;
      endcase
    end
  end

  // Break: count oversampling ticks while the line stays low
  assign br_set = tick16 && !serial_in_pin && brk_cnt_q == `EUART_BREAK_TICKS;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      brk_cnt_q <= 8'h00;
      break_reset_req <= 1'b0;
    end
    else
    begin
      break_reset_req <= br_set;
      if (serial_in_pin)
        brk_cnt_q <= 8'h00;
      else if (tick16 && brk_cnt_q <= `EUART_BREAK_TICKS)
        brk_cnt_q <= brk_cnt_q + 8'h01;
    end
  end

endmodule : euart_top

// *** euart_top_properties.sv ***
`timescale 1ns/1ps
`include "euart_regs.svh"

module euart_top_checker (
  input wire logic core_clk, // CPU clock
  input wire logic resetn, // Reset, low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic serial_in_pin, // Rx pin
  input wire logic serial_data_oe, // Rx drive on
  input wire logic serial_out_pin, // Tx pin
  input wire logic break_reset_req // Break pulse
);
  logic m0_q;
  logic m1_q;
  logic view_q;
  logic [8:0] run_q;
  logic [8:0] last_q;
  wire logic wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic shift = !m0_q && !m1_q;

  // Shadow of the mode bits
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      m0_q <= 1'b0;
      m1_q <= 1'b0;
      view_q <= 1'b0;
    end
    else if (wdone && avs_address[4:2] == `EUART_CTRL_IDX)
    begin
      m0_q <= view_q ? m0_q : avs_writedata[`EUART_CTRL_SM0];
      m1_q <= avs_writedata[`EUART_CTRL_SM1];
    end
    else if (wdone && avs_address[4:2] == `EUART_PWR_IDX)
      view_q <= avs_writedata[`EUART_PWR_FEV];
  end

  // Current and last low run on the pin
  always_ff @(posedge core_clk)
  begin
    if (!resetn || serial_in_pin)
      run_q <= 9'h000;
    else if (run_q != 9'h1FF)
      run_q <= run_q + 9'h001;
    if (!resetn)
      last_q <= 9'h000;
    else if (serial_in_pin && run_q != 9'h000)
      last_q <= run_q;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_rdata_narrow: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper bits set");
  a_break_pulse: assert property (break_reset_req |=> !break_reset_req)
    else $error("break pulse too long");
  a_break_count: assert property (break_reset_req |-> run_q >= 176 || last_q >= 176)
    else $error("break too early");
  a_shift_clock: assert property ($fell(serial_out_pin) && shift |->
    (!serial_out_pin) [*8] ##1 serial_out_pin)
    else $error("shift clock phase");
  a_oe_shift: assert property (serial_data_oe |-> shift)
    else $error("pin driven outside shift");
  a_start_len: assert property ($fell(serial_out_pin) && !shift |-> (!serial_out_pin) [*8])
    else $error("start bit too short");

  c_break: cover property (break_reset_req);
  c_shift: cover property ($fell(serial_out_pin) && shift);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule : euart_top_checker

bind euart_top euart_top_checker i_chk (.core_clk(core_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_in_pin(serial_in_pin), .serial_data_oe(serial_data_oe),
  .serial_out_pin(serial_out_pin), .break_reset_req(break_reset_req));

// *** euart_remote_model.sv ***
`timescale 1ns/1ps

module euart_remote_model (
  input wire logic core_clk, // CPU clock
  input wire logic line_in, // Device transmit line
  output logic line_out // Device receive line
);
  int bit_clks = 16;
  int nbits = 10;
  bit listen = 1'b0;
  longint cyc = 0;
  logic [10:0] frames[$];
  longint starts[$];

  initial line_out = 1'b1;

  // Cycle stamps for frame spacing
  always @(posedge core_clk) cyc <= cyc + 1;

  // Frame sent LSB first
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_out <= bits[i];
      repeat (bit_clks) @(posedge core_clk);
    end
    line_out <= 1'b1;
  endtask : send

  // Break, then idle
  task automatic hold_low(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge core_clk);
    line_out <= 1'b1;
  endtask : hold_low

  // Centre sampling; ends before a back-to-back start
  initial
  begin : rx_loop
    logic [10:0] f;
    longint t;
    forever
    begin
      @(posedge core_clk);
      if (listen && line_in === 1'b0)
      begin
        t = cyc;
        f = 11'h7FF;
        repeat (bit_clks / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++)
        begin
          f[i] = line_in;
          if (i < nbits - 1) repeat (bit_clks) @(posedge core_clk);
        end
        repeat (bit_clks / 2 - 1) @(posedge core_clk);
        frames.push_back(f);
        starts.push_back(t);
      end
    end
  end
endmodule : euart_remote_model

// *** tb_euart_top.sv ***
`timescale 1ns/1ps
`include "euart_regs.svh"

module tb_euart_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic t1_overflow = 1'b0;
  logic serial_data_out, serial_data_oe, serial_out_pin, break_reset_req, peer_line;
  wire logic rx_wire = serial_data_oe ? serial_data_out : peer_line;
  int miscompares = 0;
  int n_checks = 0;
  int brk_seen = 0;
  localparam logic [1:0] CM [5] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h1};
  localparam logic CS [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic CD [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  euart_top i_dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .t1_overflow(t1_overflow), .serial_in_pin(rx_wire),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .serial_out_pin(serial_out_pin), .break_reset_req(break_reset_req));
  euart_remote_model i_peer (.core_clk(core_clk), .line_in(serial_out_pin), .line_out(peer_line));

  always #2.5 core_clk = ~core_clk;
  // Overflow every second cycle
  always @(posedge core_clk) t1_overflow <= ~t1_overflow;
  // Count break pulses
  always @(posedge core_clk) if (break_reset_req === 1'b1) brk_seen++;

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic tmo(input int n, input int lim);
    if (n > lim)
    begin
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish;
    end
  endtask : tmo

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= {a, 2'h0};
    avs_writedata <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(negedge core_clk);
      n++;
      tmo(n, 50);
    end
    while (avs_waitrequest !== 1'b0);
    @(posedge core_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic wait_frames(input int k);
    int n;
    n = 0;
    while (i_peer.frames.size() < k)
    begin
      @(posedge core_clk);
      n++;
      tmo(n, 2000);
    end
  endtask : wait_frames

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
      tmo(n, 100);
    end
    while (serial_out_pin !== v);
  endtask : wait_lvl

  function automatic int exp_bit(input logic [1:0] m, input logic s, input logic d2, input int dv);
    if (m == 2'h2) return d2 ? 16 : 32;
    if (s) return 16 * (dv + 1);
    return d2 ? 32 : 64;
  endfunction : exp_bit

  function automatic logic [10:0] exp_frame(input logic [1:0] m, input logic [7:0] d, input logic n);
    return {1'b1, (m == 2'h1) ? 1'b1 : n, d, 1'b0};
  endfunction : exp_frame

  initial
  begin : main
    logic [7:0] d, r, b, q;
    logic n1, n2;
    int dv, bc;
    void'($urandom(35404));
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    // Reset values
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, i[2:0], 8'h00, q);
      chk(q, 0);
    end
    // Async modes and rate sources
    for (int c = 0; c < 5; c++)
    begin
      d = $urandom;
      r = $urandom;
      n1 = $urandom;
      n2 = $urandom;
      dv = $urandom_range(2, 0);
      bc = exp_bit(CM[c], CS[c], CD[c], dv);
      wr(`EUART_PWR_IDX, {CD[c], 7'h00});
      wr(`EUART_SRC_IDX, {7'h00, CS[c]});
      wr(`EUART_DIVL_IDX, dv[7:0]);
      wr(`EUART_DIVH_IDX, 8'h00);
      wr(`EUART_CTRL_IDX, {CM[c], 2'h1, n1, 3'h0});
      i_peer.bit_clks = bc;
      i_peer.nbits = (CM[c] == 2'h1) ? 10 : 11;
      i_peer.frames.delete();
      i_peer.starts.delete();
      i_peer.listen = 1'b1;
      wr(`EUART_DATA_IDX, d);
      bus(1'b0, `EUART_STAT_IDX, 8'h00, q);
      chk(q[`EUART_STAT_BUSY], 1);
      wait_frames(1);
      chk(i_peer.frames[0], exp_frame(CM[c], d, n1));
      wr(`EUART_CTRL_IDX, {CM[c], 2'h1, n1, 3'h0});
      i_peer.send(exp_frame(CM[c], r, n2), i_peer.nbits);
      bus(1'b0, `EUART_DATA_IDX, 8'h00, q);
      chk(q, r);
      bus(1'b0, `EUART_CTRL_IDX, 8'h00, q);
      chk(q[2:0], {(CM[c] == 2'h1) ? 1'b1 : n2, 2'h1});
    end
    // Low stop bit: framing error
    wr(`EUART_CTRL_IDX, 8'h50);
    i_peer.send({2'h0, r, 1'b0}, 10);
    bus(1'b0, `EUART_STAT_IDX, 8'h00, q);
    chk(q[`EUART_STAT_FE], 1);
    wr(`EUART_PWR_IDX, 8'hC0);
    bus(1'b0, `EUART_CTRL_IDX, 8'h00, q);
    chk(q[7], 1);
    wr(`EUART_PWR_IDX, 8'h80);
    // Break
    i_peer.hold_low(12 * bc);
    chk(brk_seen, 1);
    bus(1'b0, `EUART_STAT_IDX, 8'h00, q);
    chk(q[`EUART_STAT_BR], 1);
    // Double buffer, ninth bit before each write
    i_peer.bit_clks = 16;
    i_peer.nbits = 11;
    i_peer.frames.delete();
    i_peer.starts.delete();
    wr(`EUART_STAT_IDX, 8'h80);
    wr(`EUART_CTRL_IDX, {2'h2, 2'h1, n1, 3'h0});
    wr(`EUART_DATA_IDX, d);
    wr(`EUART_CTRL_IDX, {2'h2, 2'h1, n2, 3'h0});
    wr(`EUART_DATA_IDX, r);
    wait_frames(1);
    bus(1'b0, `EUART_STAT_IDX, 8'h00, q);
    chk(q[`EUART_STAT_HOLD], 0);
    bus(1'b0, `EUART_CTRL_IDX, 8'h00, q);
    chk(q[`EUART_CTRL_TI], 1);
    wait_frames(2);
    chk(i_peer.frames[0], exp_frame(2'h2, d, n1));
    chk(i_peer.frames[1], exp_frame(2'h2, r, n2));
    chk(11'(i_peer.starts[1] - i_peer.starts[0]), 11'h0B0);
    // Shift mode transmit
    i_peer.listen = 1'b0;
    wr(`EUART_STAT_IDX, 8'h00);
    wr(`EUART_CTRL_IDX, 8'h00);
    wr(`EUART_DATA_IDX, d);
    for (int i = 0; i < 8; i++)
    begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      b[i] = serial_data_out;
    end
    chk(b, d);
    tally_and_finish;
  end
endmodule : tb_euart_top
